// file: icc_pkg.sv
/*
  shared constants and types of the instruction-cache control unit.
  assumes one core clock; no timing figures are involved.
*/
`default_nettype none
package icc_pkg;
  // function codes of the select operand
  localparam logic [31:0] FN_OFF    = 32'h0;
  localparam logic [31:0] FN_ON     = 32'h1;
  localparam logic [31:0] FN_INVAL  = 32'h2;
  localparam logic [31:0] FN_LOCK   = 32'h3;
  localparam logic [31:0] FN_STAT   = 32'h4;
  localparam logic [31:0] FN_LKSTAT = 32'h5;
  localparam logic [31:0] FN_DUMP   = 32'h6;
  // cache geometry and status fields
  localparam logic [3:0]  LOG_ATOM  = 4'h2;
  localparam logic [3:0]  LOG_LINE  = 4'h2;
  localparam logic [3:0]  LOG_SETS  = 4'h9;
  localparam logic [11:0] WAYS_M1   = 12'h001;
  localparam logic [15:0] BLK_WORDS = 16'h0800;
  localparam logic [7:0]  BLK_LOCKABLE = 8'h01;
  localparam logic [15:0] LAST_SET  = 16'h01ff;
  localparam logic [10:0] LAST_WORD = 11'h7ff;
  localparam logic [3:0]  LAST_IDX  = 4'hc;
  localparam logic [3:0]  WAY1_IDX  = 4'h7;
  localparam logic [31:0] WORD_STEP = 32'h4;
  localparam logic [31:0] LINE_MASK = 32'hfffffff0;
  // reset values
  localparam logic        EN_RST    = 1'b0;
  localparam logic [1:0]  LOCK_RST  = 2'b00;
  // one request from the pipeline
  typedef struct packed {
    logic [31:0] fsel;
    logic [31:0] second_source_operand;
    logic [31:0] srcdst;
    logic        supervisor;
  } icc_req_s;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LREQ = 5'b00010,
    ST_LWT  = 5'b00100,
    ST_DUMP = 5'b01000,
    ST_FIN  = 5'b10000
  } icc_state_e;
endpackage
`default_nettype wire

// file: icc_ctl.sv
/*
  instruction-cache control unit: runs one cache management operation per request,
  owns the cache arrays, fetches code for load-and-lock, writes dumps to memory.
  assumes the pipeline holds the request only while req_ready_out is high and
  waits for done_out; memory ports use valid/ready in the core clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module icc_ctl (
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic              req_valid_in,
  input  wire icc_pkg::icc_req_s req_in,
  output logic                   req_ready_out,
  output logic                   done_out,
  output logic [31:0]            result_out,
  output logic                   result_we_out,
  output logic                   type_fault_out,
  output logic                   operand_fault_out,
  output logic                   cache_en_out,
  output logic                   mem_rd_valid_out,
  output logic [31:0]            mem_rd_addr_out,
  input  wire logic              mem_rd_ready_in,
  input  wire logic              mem_rd_data_valid_in,
  input  wire logic [31:0]       mem_rd_data_in,
  output logic                   mem_wr_valid_out,
  output logic [31:0]            mem_wr_addr_out,
  output logic [31:0]            mem_wr_data_out,
  input  wire logic              mem_wr_ready_in
);
  import icc_pkg::*;

  icc_state_e  state_reg;
  logic [31:0] line_mem [0:4095];  // {set, way, word}
  logic [18:0] tag_mem  [0:1023];  // {set, way}
  logic [4095:0] valid_reg;
  logic [1:0]  lock_reg;           // one lockable block is a whole way
  logic        en_reg;
  logic [31:0] addr_reg;
  logic [10:0] cnt_reg;
  logic [8:0]  set_reg;
  logic [8:0]  end_reg;
  logic [3:0]  idx_reg;
  logic        last_reg;
  logic        first_reg;
  logic        done_reg, rwe_reg, tf_reg, of_reg;
  logic [31:0] res_reg;
  logic        rd_v_reg, wr_v_reg;
  logic [31:0] wr_a_reg, wr_d_reg;

  logic        take, priv_ok, is_fn;
  logic [15:0] dend;
  logic        range_bad;
  logic        wr_free, dump_issue, fill;
  logic        clr_all, set_lock;
  logic [11:0] fill_idx;
  logic [31:0] dump_word;
  logic [3:0]  slot;
  logic        dway;

  assign take    = req_valid_in && (state_reg == ST_IDLE);
  assign priv_ok = req_in.supervisor;
  assign is_fn   = (req_in.fsel <= FN_DUMP); // full operand compared
  // clamp the end set before comparing
  assign dend = (req_in.srcdst[31:16] > LAST_SET) ? LAST_SET : req_in.srcdst[31:16];
  assign range_bad = (req_in.srcdst[15:0] > dend)
                     || (req_in.second_source_operand[1:0] != 2'b00);
  assign clr_all = take && priv_ok && (req_in.fsel == FN_INVAL || req_in.fsel == FN_LOCK);
  assign wr_free = !wr_v_reg || mem_wr_ready_in;
  assign dump_issue = (state_reg == ST_DUMP) && wr_free && !last_reg;
  assign fill = (state_reg == ST_LWT) && mem_rd_data_valid_in;
  assign fill_idx = {addr_reg[12:4], 1'b0, addr_reg[3:2]}; // loaded block goes to way 0
  assign set_lock = fill && (cnt_reg == LAST_WORD);

  // word picked for the dump slot idx_reg of set set_reg
  always_comb begin
    dway = (idx_reg >= WAY1_IDX);
    slot = dway ? (idx_reg - WAY1_IDX) : (idx_reg - 4'h1);
    dump_word = 32'h0;
    if (idx_reg == 4'h0) begin
      dump_word = {30'h0, lock_reg};
    end else if (slot == 4'h0) begin
      dump_word = {13'h0, tag_mem[{set_reg, dway}]};
    end else if (slot == 4'h1) begin
      dump_word = {28'h0, valid_reg[{set_reg, dway, 2'b00} +: 4]};
    end else begin
      dump_word = line_mem[{set_reg, dway, slot[1:0] - 2'h2}];
    end
  end

  // sequencer: accept, decode, run multi-cycle functions
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      addr_reg  <= 32'h0;
      cnt_reg   <= 11'h0;
      set_reg   <= 9'h0;
      end_reg   <= 9'h0;
      idx_reg   <= 4'h0;
      last_reg  <= 1'b0;
      rd_v_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take && priv_ok) begin
            if (req_in.fsel == FN_LOCK) begin
              addr_reg <= req_in.second_source_operand & LINE_MASK;
              cnt_reg  <= 11'h0;
              if (req_in.srcdst != 32'h0) begin
                state_reg <= ST_LREQ;
                rd_v_reg  <= 1'b1;
              end
            end else if (req_in.fsel == FN_DUMP && !range_bad) begin
              addr_reg  <= req_in.second_source_operand;
              set_reg   <= req_in.srcdst[8:0];
              end_reg   <= dend[8:0];
              idx_reg   <= 4'h0;
              last_reg  <= 1'b0;
              state_reg <= ST_DUMP;
            end
          end
        end
        ST_LREQ: begin
          if (mem_rd_ready_in) begin
            rd_v_reg  <= 1'b0;
            state_reg <= ST_LWT;
          end
        end
        ST_LWT: begin
          if (mem_rd_data_valid_in) begin
            addr_reg <= addr_reg + WORD_STEP;
            cnt_reg  <= cnt_reg + 11'h1;
            if (cnt_reg == LAST_WORD) begin
              state_reg <= ST_FIN;
            end else begin
              rd_v_reg  <= 1'b1;
              state_reg <= ST_LREQ;
            end
          end
        end
        ST_DUMP: begin
          if (dump_issue) begin
            addr_reg <= addr_reg + WORD_STEP;
            if (idx_reg == LAST_IDX) begin
              idx_reg <= 4'h0;
              set_reg <= set_reg + 9'h1;
              last_reg <= (set_reg == end_reg);
            end else begin
              idx_reg <= idx_reg + 4'h1;
            end
          end else if (last_reg && wr_free) begin
            state_reg <= ST_FIN;
          end
        end
        ST_FIN: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // enable flag, valid bits and locks
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_reg    <= EN_RST;
      valid_reg <= '0;
      lock_reg  <= LOCK_RST;
    end else begin
      if (take && priv_ok && req_in.fsel == FN_OFF) begin
        en_reg <= 1'b0;
      end
      if (take && priv_ok && req_in.fsel == FN_ON) begin
        en_reg <= 1'b1;
      end
      if (clr_all) begin
        valid_reg <= '0;
        lock_reg  <= LOCK_RST;
      end else if (fill) begin
        valid_reg[fill_idx] <= 1'b1;
        if (set_lock) begin
          lock_reg[0] <= 1'b1;
        end
      end
    end
  end

  // array writes during load-and-lock; arrays need no reset, valid bits guard them
  always_ff @(posedge clk_in) begin
    if (fill) begin
      line_mem[fill_idx] <= mem_rd_data_in;
      tag_mem[fill_idx[11:2]] <= addr_reg[31:13];
    end
  end

  // result and completion pulses
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_reg <= 1'b0;
      rwe_reg  <= 1'b0;
      tf_reg   <= 1'b0;
      of_reg   <= 1'b0;
      res_reg  <= 32'h0;
    end else begin
      done_reg <= 1'b0;
      rwe_reg  <= 1'b0;
      tf_reg   <= 1'b0;
      of_reg   <= 1'b0;
      if (take) begin
        if (!priv_ok) begin
          tf_reg   <= 1'b1;
          done_reg <= 1'b1;
        end else if (!is_fn || (req_in.fsel == FN_DUMP && range_bad)) begin
          of_reg   <= 1'b1;
          done_reg <= 1'b1;
        end else if (req_in.fsel == FN_STAT) begin
          res_reg  <= {4'h0, WAYS_M1, LOG_SETS, LOG_LINE, LOG_ATOM, 3'h0, en_reg};
          rwe_reg  <= 1'b1;
          done_reg <= 1'b1;
        end else if (req_in.fsel == FN_LKSTAT) begin
          res_reg  <= {7'h0, lock_reg[0], BLK_WORDS, BLK_LOCKABLE};
          rwe_reg  <= 1'b1;
          done_reg <= 1'b1;
        end else if (req_in.fsel != FN_DUMP &&
                     !(req_in.fsel == FN_LOCK && req_in.srcdst != 32'h0)) begin
          done_reg <= 1'b1;
        end
      end
      if (state_reg == ST_FIN) begin
        done_reg <= 1'b1;
      end
    end
  end

  // dump write port; the word stays until memory accepts it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_v_reg  <= 1'b0;
      wr_a_reg  <= 32'h0;
      wr_d_reg  <= 32'h0;
      first_reg <= 1'b0;
    end else begin
      if (take) begin
        first_reg <= 1'b1;
      end
      if (dump_issue) begin
        wr_v_reg  <= 1'b1;
        wr_a_reg  <= addr_reg;
        wr_d_reg  <= dump_word;
        first_reg <= 1'b0;
      end else if (mem_wr_ready_in) begin
        wr_v_reg <= 1'b0;
      end
    end
  end

  assign req_ready_out     = (state_reg == ST_IDLE);
  assign done_out          = done_reg;
  assign result_out        = res_reg;
  assign result_we_out     = rwe_reg;
  assign type_fault_out    = tf_reg;
  assign operand_fault_out = of_reg;
  assign cache_en_out      = en_reg;
  assign mem_rd_valid_out  = rd_v_reg;
  assign mem_rd_addr_out   = addr_reg;
  assign mem_wr_valid_out  = wr_v_reg;
  assign mem_wr_addr_out   = wr_a_reg;
  assign mem_wr_data_out   = wr_d_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_priv_fault: assert property (take && !priv_ok |=> type_fault_out && done_out)
    else $error("privilege fault missing");
  chk_priv_keep: assert property (take && !priv_ok
    |=> $stable(cache_en_out) && $stable(lock_reg))
    else $error("state changed outside supervisor");
  chk_enable_set: assert property (take && priv_ok && req_in.fsel == FN_ON |=> cache_en_out)
    else $error("enable not applied");
  chk_status_word: assert property (take && priv_ok && req_in.fsel == FN_STAT
    |=> result_we_out && result_out[27:1] == 27'h000c910)
    else $error("status word wrong");
  chk_lock_status: assert property (take && priv_ok && req_in.fsel == FN_LKSTAT
    |=> result_out[23:8] == 16'h0800 && result_out[24] == lock_reg[0])
    else $error("lock status wrong");
  chk_bad_select: assert property (take && priv_ok && req_in.fsel > 32'h6
    |=> operand_fault_out && $stable(cache_en_out) && state_reg == ST_IDLE)
    else $error("bad select not faulted");
  chk_inval_all: assert property (take && priv_ok && req_in.fsel == FN_INVAL
    |=> lock_reg == 2'b00 && valid_reg == '0)
    else $error("invalidate incomplete");
  chk_range_fault: assert property (take && priv_ok && req_in.fsel == FN_DUMP
    && range_bad |=> operand_fault_out && !mem_wr_valid_out)
    else $error("dump range not faulted");
  chk_load_addr: assert property (take && priv_ok && req_in.fsel == FN_LOCK
    && req_in.srcdst != 32'h0 |=> mem_rd_valid_out
    && mem_rd_addr_out == {$past(req_in.second_source_operand[31:4]), 4'h0})
    else $error("load address wrong");
  chk_dump_start: assert property (take && priv_ok && req_in.fsel == FN_DUMP
    && !range_bad |=> ##1 mem_wr_valid_out
    && mem_wr_addr_out == $past(req_in.second_source_operand, 2))
    else $error("dump start address wrong");
  chk_dump_stride: assert property (dump_issue && !first_reg
    |=> mem_wr_addr_out == $past(mem_wr_addr_out) + 32'h4)
    else $error("dump stride wrong");
  chk_done_after: assert property (done_out |-> !mem_wr_valid_out && !mem_rd_valid_out)
    else $error("done before effects finished");

  // a read request must not vanish or move while memory stalls it
  chk_read_hold: assert property (mem_rd_valid_out && !mem_rd_ready_in
    |=> mem_rd_valid_out && $stable(mem_rd_addr_out))
    else $error("read request dropped while stalled");
  // a stalled dump word keeps its address and data
  chk_write_hold: assert property (mem_wr_valid_out && !mem_wr_ready_in
    |=> mem_wr_valid_out && $stable(mem_wr_addr_out) && $stable(mem_wr_data_out))
    else $error("dump word dropped while stalled");
  // way 0 locks with its last stored word, completion one cycle later
  chk_lock_done: assert property (set_lock |=> lock_reg[0] ##1 done_out)
    else $error("lock or completion missing after last fill");
  // off request clears the enable and completes at once
  chk_disable_clr: assert property (take && priv_ok && req_in.fsel == FN_OFF
    |=> !cache_en_out && done_out)
    else $error("disable not applied");
  // privilege fault wins, even over a bad select value
  chk_fault_prio: assert property (take && !priv_ok
    |=> !operand_fault_out && !result_we_out)
    else $error("operand fault or result outside supervisor");
  // every set opens with its lock bits
  chk_set_data: assert property (dump_issue && idx_reg == 4'h0
    |=> mem_wr_data_out == {30'h0, lock_reg})
    else $error("set data word wrong");
  // dump writes only while the dump runs, so completion cannot overtake them
  chk_wr_in_dump: assert property (mem_wr_valid_out |-> state_reg == ST_DUMP)
    else $error("dump write outside dump state");
endmodule // icc_ctl
`default_nettype wire

// file: icc_mem_model.sv
/*
  memory partner of the cache control unit: answers each read with its own
  address as data and accepts writes. assumes one core clock; slow_in adds stalls.
*/
`timescale 1ns/100ps
`default_nettype none
module icc_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        slow_in,
  input  wire logic        rd_valid_in,
  input  wire logic [31:0] rd_addr_in,
  output logic             rd_ready_out,
  output logic             rd_data_valid_out,
  output logic [31:0]      rd_data_out,
  input  wire logic        wr_valid_in,
  output logic             wr_ready_out,
  output logic [31:0]      rd_count_out
);
  logic [1:0]  tick_reg;
  logic        pend_reg;
  logic [31:0] paddr_reg;
  // stall three cycles of four when slow, so a handshake completes only when tick_reg is zero
  assign rd_ready_out = !(slow_in && tick_reg != 2'h0);
  assign wr_ready_out = rd_ready_out;
  // one read outstanding; the data line toggles outside its pulse
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_reg          <= 2'h0;
      pend_reg          <= 1'b0;
      paddr_reg         <= 32'h0;
      rd_data_valid_out <= 1'b0;
      rd_data_out       <= 32'h0;
      rd_count_out      <= 32'h0;
    end else begin
      tick_reg          <= tick_reg + 2'h1;
      rd_data_valid_out <= 1'b0;
      rd_data_out       <= ~rd_data_out;
      if (rd_valid_in && rd_ready_out) begin
        pend_reg     <= 1'b1;
        paddr_reg    <= rd_addr_in;
        rd_count_out <= rd_count_out + 32'h1;
      end else if (pend_reg && rd_ready_out) begin
        rd_data_valid_out <= 1'b1;
        rd_data_out       <= paddr_reg;
        pend_reg          <= 1'b0;
      end
    end
  end
endmodule // icc_mem_model
`default_nettype wire

// file: icc_ctl_bench.sv
/*
  self-checking bench of the cache control unit with a memory partner.
  assumes the request, completion and memory handshakes of the unit's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module icc_ctl_bench;
  import icc_pkg::*;
  logic clk, rstn, rq_v, rq_rdy, done, we, tf, of, en, slow;
  logic rv, rr, rdv, wv, wr;
  logic [31:0] res, ra, rd, wa, wd, nrd;
  icc_req_s rq;
  logic [31:0] la [0:63];
  logic [31:0] ld [0:63];
  int nw, n_fail, compares, waited;
  logic [31:0] o_res;
  logic o_we, o_tf, o_of;
  icc_ctl dut (.clk_in(clk), .rstn_in(rstn), .req_valid_in(rq_v), .req_in(rq),
    .req_ready_out(rq_rdy), .done_out(done), .result_out(res), .result_we_out(we),
    .type_fault_out(tf), .operand_fault_out(of), .cache_en_out(en),
    .mem_rd_valid_out(rv), .mem_rd_addr_out(ra), .mem_rd_ready_in(rr),
    .mem_rd_data_valid_in(rdv), .mem_rd_data_in(rd), .mem_wr_valid_out(wv),
    .mem_wr_addr_out(wa), .mem_wr_data_out(wd), .mem_wr_ready_in(wr));
  icc_mem_model mem (.clk_in(clk), .rstn_in(rstn), .slow_in(slow), .rd_valid_in(rv),
    .rd_addr_in(ra), .rd_ready_out(rr), .rd_data_valid_out(rdv), .rd_data_out(rd),
    .wr_valid_in(wv), .wr_ready_out(wr), .rd_count_out(nrd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // log the first 64 accepted dump words for later comparison
  always @(posedge clk) begin
    if (wv && wr && nw < 64) begin
      la[nw] <= wa;
      ld[nw] <= wd;
      nw <= nw + 1;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request; outputs captured in the done cycle, waited counts cycles
  task automatic op(input logic [31:0] f, input logic [31:0] s2, input logic [31:0] sd,
                    input logic sup);
    @(posedge clk);
    rq_v <= 1'b1;
    rq <= '{fsel: f, second_source_operand: s2, srcdst: sd, supervisor: sup};
    @(posedge clk);
    rq_v <= 1'b0;
    for (waited = 1; waited < 20000; waited++) begin
      @(negedge clk);
      if (done === 1'b1) break;
      @(posedge clk);
    end
    o_res = res;
    o_we = we;
    o_tf = tf;
    o_of = of;
    chk(rq_rdy, 1'b1);
    if (waited >= 20000) chk(32'h1, 32'h0);
  endtask
  function automatic logic [31:0] st(input logic e);
    return {4'h0, 12'h001, 4'h9, 4'h2, 4'h2, 3'h0, e};
  endfunction
  task automatic t_status();
    op(FN_STAT, 0, 0, 1'b1);
    chk(o_res, st(1'b0));
    chk({o_we, waited[3:0]}, {1'b1, 4'h1});
    op(FN_ON, 0, 0, 1'b1);
    chk({o_we, en}, 2'b01);
    op(FN_STAT, 0, 0, 1'b1);
    chk(o_res, st(1'b1));
    op(FN_OFF, 0, 0, 1'b1);
    chk(en, 1'b0);
  endtask
  task automatic t_faults();
    op(FN_ON, 0, 0, 1'b0);
    chk({o_tf, o_of, en}, 3'b100);
    op(32'h7, 0, 0, 1'b0);
    chk({o_tf, o_of}, 2'b10);
    op(32'h7, 0, 0, 1'b1);
    chk({o_tf, o_of, en}, 3'b010);
    op(32'h101, 0, 0, 1'b1);
    chk({o_of, en}, 2'b10);
  endtask
  task automatic t_lock();
    slow = 1'b1;
    op(FN_LOCK, 32'h2004, 32'h1, 1'b1);
    chk(nrd, 32'd2048);
    slow = 1'b0;
    op(FN_LKSTAT, 0, 0, 1'b1);
    chk(o_res, {8'h01, 16'h0800, 8'h01});
  endtask
  task automatic t_dump();
    nw = 0;
    op(FN_DUMP, 32'h8000, {16'h0001, 16'h0000}, 1'b1);
    chk(nw, 26);
    for (int i = 0; i < 26; i++) chk(la[i], 32'h8000 + 4 * i);
    chk(ld[0], 32'h1);
    chk(ld[1], 32'h1);
    chk(ld[2], 32'hf);
    for (int k = 0; k < 4; k++) chk(ld[3 + k], 32'h2000 + 4 * k);
    chk(ld[8], 32'h0);
    chk(ld[13], 32'h1);
    for (int k = 0; k < 4; k++) chk(ld[16 + k], 32'h2010 + 4 * k);
    nw = 0;
    slow = 1'b1;
    op(FN_DUMP, 32'h9000, {16'hffff, 16'h01ff}, 1'b1);
    slow = 1'b0;
    chk(nw, 13);
    chk(ld[3], 32'h3ff0);
    nw = 0;
    op(FN_DUMP, 32'h9000, {16'h0000, 16'h0001}, 1'b1);
    chk({o_of, nw[3:0]}, {1'b1, 4'h0});
    op(FN_DUMP, 32'h9002, 32'h0, 1'b1);
    chk({o_of, nw[3:0]}, {1'b1, 4'h0});
  endtask
  task automatic t_inval();
    op(FN_INVAL, 0, 0, 1'b1);
    op(FN_LKSTAT, 0, 0, 1'b1);
    chk(o_res, {8'h00, 16'h0800, 8'h01});
    nw = 0;
    op(FN_DUMP, 32'ha000, 32'h0, 1'b1);
    chk(ld[0], 32'h0);
    chk(ld[2], 32'h0);
  endtask
  // watchdog: the load dominates, well under this span
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    rq_v = 1'b0;
    rq = '0;
    slow = 1'b0;
    nw = 0;
    n_fail = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chk(en, 1'b0);
    t_status();
    t_faults();
    t_lock();
    t_dump();
    t_inval();
    stop_test();
  end
endmodule // icc_ctl_bench
`default_nettype wire
